// ---- src/ssp_pkg.sv ----
package ssp_pkg;

  // Register bank geometry
  localparam int SSP_NUM_REGS = 16;
  localparam int SSP_BYTE_W = 8;
  localparam int SSP_ADDR_W = 4;

  // Frame geometry, counted in setup clock slots
  localparam int SSP_CMD_BITS = 8;
  localparam int SSP_WORD_BITS = 16;

  // Configuration byte zero, charge pump off bit
  localparam int SSP_CP_OFF_REG = 0;
  localparam int SSP_CP_OFF_BIT = 2;

  // Reset value of every register byte
  localparam logic [7:0] SSP_REG_RST = 8'h00;

  // Link timing: fastest setup clock and the system clock rate
  localparam int SETUP_CLOCK_MAX_KHZ = 2048;
  localparam int SSP_SYS_CLK_KHZ = 100000;
  // Least system cycles per setup clock period, rounded up
  localparam int SSP_LINK_MIN_CYC = (SSP_SYS_CLK_KHZ + SETUP_CLOCK_MAX_KHZ - 1) / SETUP_CLOCK_MAX_KHZ;

  typedef logic [SSP_BYTE_W-1:0] ssp_byte_t;
  typedef logic [SSP_NUM_REGS-1:0][SSP_BYTE_W-1:0] ssp_bank_t;

  // First byte of a transfer: read flag, spare bits, register address
  typedef struct packed {
    logic rd;
    logic [2:0] spare;
    logic [SSP_ADDR_W-1:0] addr;
  } ssp_cmd_s;

  // Write handed from the link domain to the system domain
  typedef struct packed {
    logic [SSP_ADDR_W-1:0] addr;
    ssp_byte_t data;
  } ssp_wr_s;

endpackage

// ---- src/ssp_setup_port.sv ----
`timescale 1ns/1ps

module ssp_setup_port
  import ssp_pkg::*;
#(
  parameter int NUM_REGS = SSP_NUM_REGS
)
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_powerdown_reset_n,
  input wire logic i_setup_clock,
  input wire logic i_setup_select_n,
  input wire logic i_setup_data_in,
  output logic o_setup_data_out,
  output logic o_setup_data_out_oe_n,
  output ssp_bank_t o_reg_bank,
  output logic o_charge_pump_off,
  output logic o_powerdown,
  output logic o_core_reset
);

  if (NUM_REGS < 1 || NUM_REGS > SSP_NUM_REGS)
  begin : g_bad_regs
    $error("NUM_REGS must lie between 1 and 16");
  end

  // Link domain resets: frame logic also clears whenever select is high
  logic frame_rst;
  logic held_rst;
  assign frame_rst = i_sys_rst | ~i_powerdown_reset_n | i_setup_select_n;
  assign held_rst = i_sys_rst | ~i_powerdown_reset_n;

  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  ssp_byte_t sh_q;
  ssp_byte_t sh_d;
  ssp_cmd_s held_q;
  ssp_cmd_s held_d;
  logic held_valid_q;
  logic held_valid_d;
  ssp_byte_t rd_byte_q;
  ssp_byte_t rd_byte_d;
  ssp_wr_s wr_q;
  ssp_wr_s wr_d;
  logic wr_tog_q;
  logic wr_tog_d;
  logic [4:0] pos_w;
  logic drive_w;
  logic dout_q;
  logic dout_d;
  logic oe_n_q;
  logic oe_n_d;
  ssp_bank_t bank_q;
  ssp_bank_t bank_d;

  // Link side: shift in, count slots, split or join the two bytes
  always_comb
  begin
    cnt_d = cnt_q;
    sh_d = {sh_q[6:0], i_setup_data_in};
    held_d = held_q;
    held_valid_d = held_valid_q;
    rd_byte_d = rd_byte_q;
    wr_d = wr_q;
    wr_tog_d = wr_tog_q;
    if (cnt_q == 5'd0 && held_valid_q)
    begin
      // Second frame of a split transfer resumes at the data byte
      cnt_d = 5'(SSP_CMD_BITS + 1);
      held_valid_d = 1'b0;
    end
    else if (cnt_q < 5'(SSP_WORD_BITS))
    begin
      cnt_d = cnt_q + 5'd1;
    end
    if (cnt_q == 5'(SSP_CMD_BITS - 1))
    begin
      held_d = ssp_cmd_s'(sh_d);
      held_valid_d = 1'b1;
      // Bank is quiet here: the last write committed many link slots ago
      rd_byte_d = bank_q[sh_d[SSP_ADDR_W-1:0]];
    end
    if (cnt_q == 5'(SSP_CMD_BITS))
    begin
      held_valid_d = 1'b0;
    end
    if (cnt_q == 5'(SSP_WORD_BITS - 1) && !held_q.rd)
    begin
      wr_d.addr = held_q.addr;
      wr_d.data = sh_d;
      wr_tog_d = ~wr_tog_q;
    end
  end

  always_ff @(posedge i_setup_clock or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      cnt_q <= 5'd0;
      sh_q <= '0;
    end
    else
    begin
      cnt_q <= cnt_d;
      sh_q <= sh_d;
    end
  end

  always_ff @(posedge i_setup_clock or posedge held_rst)
  begin
    if (held_rst)
    begin
      held_q <= '0;
      held_valid_q <= 1'b0;
      rd_byte_q <= '0;
    end
    else
    begin
      held_q <= held_d;
      held_valid_q <= held_valid_d;
      rd_byte_q <= rd_byte_d;
    end
  end

  // Held stable from one write to the next for the system side to read
  always_ff @(posedge i_setup_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      wr_q <= '0;
      wr_tog_q <= 1'b0;
    end
    else
    begin
      wr_q <= wr_d;
      wr_tog_q <= wr_tog_d;
    end
  end

  // Output side: slot position seen at the falling edge
  always_comb
  begin
    pos_w = (cnt_q == 5'd0 && held_valid_q) ? 5'(SSP_CMD_BITS) : cnt_q;
    drive_w = held_q.rd && pos_w >= 5'(SSP_CMD_BITS) && pos_w < 5'(SSP_WORD_BITS);
    oe_n_d = ~drive_w;
    dout_d = drive_w ? rd_byte_q[3'(5'd15 - pos_w)] : 1'b0;
  end

  always_ff @(negedge i_setup_clock or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      dout_q <= 1'b0;
      oe_n_q <= 1'b1;
    end
    else
    begin
      dout_q <= dout_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign o_setup_data_out = dout_q;
  assign o_setup_data_out_oe_n = oe_n_q;

  // System side: synchronisers for the reset pin and the write toggle
  logic pd_s1_q;
  logic pd_s2_q;
  logic pd_prev_q;
  logic tog_s1_q;
  logic tog_s2_q;
  logic tog_prev_q;
  logic pd_rise_w;
  logic cp_off_d;
  logic cp_off_q;
  logic pdn_d;
  logic pdn_q;
  logic core_rst_q;

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      pd_s1_q <= 1'b0;
      pd_s2_q <= 1'b0;
      pd_prev_q <= 1'b0;
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
      tog_prev_q <= 1'b0;
    end
    else
    begin
      pd_s1_q <= i_powerdown_reset_n;
      pd_s2_q <= pd_s1_q;
      pd_prev_q <= pd_s2_q;
      tog_s1_q <= wr_tog_q;
      tog_s2_q <= tog_s1_q;
      tog_prev_q <= tog_s2_q;
    end
  end

  always_comb
  begin
    pd_rise_w = pd_s2_q & ~pd_prev_q;
    bank_d = bank_q;
    if (pd_rise_w)
    begin
      bank_d = {SSP_NUM_REGS{SSP_REG_RST}};
    end
    else if (pd_s2_q && tog_s2_q != tog_prev_q && 32'(wr_q.addr) < NUM_REGS)
    begin
      bank_d[wr_q.addr] = wr_q.data;
    end
    cp_off_d = bank_d[SSP_CP_OFF_REG][SSP_CP_OFF_BIT];
    pdn_d = ~pd_s2_q;
  end

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      bank_q <= {SSP_NUM_REGS{SSP_REG_RST}};
      cp_off_q <= 1'b0;
      pdn_q <= 1'b1;
      core_rst_q <= 1'b0;
    end
    else
    begin
      bank_q <= bank_d;
      cp_off_q <= cp_off_d;
      pdn_q <= pdn_d;
      core_rst_q <= pd_rise_w;
    end
  end

  assign o_reg_bank = bank_q;
  assign o_charge_pump_off = cp_off_q;
  assign o_powerdown = pdn_q;
  assign o_core_reset = core_rst_q;

  // Checks
  idle_hiz_a: assert property (
    @(posedge i_clock) disable iff (i_sys_rst)
    i_setup_select_n |-> o_setup_data_out_oe_n)
    else $error("data output driven while select is high");

  byte_split_a: assert property (
    @(posedge i_setup_clock) disable iff (frame_rst)
    (cnt_q == 5'd0 && held_valid_q) |=> (cnt_q == 5'd9 && !held_valid_q))
    else $error("second byte frame did not resume at slot nine");

  out_bit_a: assert property (
    @(posedge i_setup_clock) disable iff (frame_rst)
    !o_setup_data_out_oe_n |-> (o_setup_data_out == rd_byte_q[3'(5'd15 - pos_w)]))
    else $error("read bit not set up before the rising edge");

  // Completes at the first edge of the next frame, so select high must not cancel it
  shift_in_a: assert property (
    @(posedge i_setup_clock) disable iff (held_rst)
    (cnt_q == 5'd15 && !held_q.rd) |=> (wr_q.data[0] == $past(i_setup_data_in)))
    else $error("last input bit not taken at the rising edge");

  wr_commit_a: assert property (
    @(posedge i_clock) disable iff (i_sys_rst || !pd_s2_q || !pd_prev_q)
    ($changed(wr_tog_q) && 32'(wr_q.addr) < NUM_REGS) |->
      ##3 (bank_q[wr_q.addr] == wr_q.data))
    else $error("write not committed three system cycles after handover");

  wr_drop_a: assert property (
    @(posedge i_clock) disable iff (i_sys_rst || !pd_s2_q || !pd_prev_q)
    ($changed(wr_tog_q) && 32'(wr_q.addr) >= NUM_REGS) |->
      ##3 (bank_q[wr_q.addr] == SSP_REG_RST))
    else $error("write to an absent register changed the bank");

  cmd_hiz_a: assert property (
    @(posedge i_setup_clock) disable iff (frame_rst)
    (pos_w < 5'(SSP_CMD_BITS) || !held_q.rd) |-> o_setup_data_out_oe_n)
    else $error("data output driven outside read data slots");

  sequence pd_rise_s;
    $rose(pd_s2_q);
  endsequence

  sequence core_pulse_s;
    o_core_reset ##1 !o_core_reset;
  endsequence

  wake_reset_a: assert property (
    @(posedge i_clock) disable iff (i_sys_rst)
    pd_rise_s |=> (core_pulse_s and (o_reg_bank == {SSP_NUM_REGS{SSP_REG_RST}})))
    else $error("wake up did not pulse core reset and clear registers");

  power_down_a: assert property (
    @(posedge i_clock) disable iff (i_sys_rst)
    !pd_s2_q |=> o_powerdown)
    else $error("power down not shown while reset pin low");

  abort_idle_a: assert property (
    @(posedge i_clock) disable iff (i_sys_rst)
    i_setup_select_n |-> (cnt_q == 5'd0))
    else $error("slot counter not idle while select is high");

  abort_nowr_a: assert property (
    @(posedge i_clock) disable iff (i_sys_rst)
    (i_setup_select_n && $past(i_setup_select_n)) |-> $stable(wr_tog_q))
    else $error("write issued while select is high");

endmodule

// ---- sim/ssp_host_model.sv ----
`timescale 1ns/1ps
module ssp_host_model (
  output logic o_setup_clock,
  output logic o_setup_select_n,
  output logic o_setup_data_in,
  input wire logic i_setup_data_out,
  input wire logic i_setup_data_out_oe_n
);
  initial
  begin
    o_setup_clock = 1'b1;
    o_setup_select_n = 1'b1;
    o_setup_data_in = 1'b0;
  end
  // Clock idles high and stands still outside frames
  task automatic xfer(input logic [15:0] w, input int n, input bit split,
                      output logic [7:0] rd);
    rd = 8'h00;
    o_setup_select_n = 1'b0;
    #103;
    for (int i = 0; i < n; i++)
    begin
      if (split && i == 8)
      begin
        #100 o_setup_select_n = 1'b1;
        #300 o_setup_select_n = 1'b0;
        #100;
      end
      o_setup_clock = 1'b0;
      o_setup_data_in = w[15-i];
      #80;
      o_setup_clock = 1'b1;
      if (i >= 8)
        rd = {rd[6:0], i_setup_data_out_oe_n ? 1'bx : i_setup_data_out};
      #80;
    end
    #100 o_setup_select_n = 1'b1;
    o_setup_data_in = ~o_setup_data_in;
    // Select stays high between transfers so the frame logic clears
    #200;
  endtask
endmodule

// ---- sim/serial_setup_port_tb_top.sv ----
`timescale 1ns/1ps
module serial_setup_port_tb_top;
  import ssp_pkg::*;
  logic clk, rst, pdr_n, sck, sel_n, sdi, sdo, oe_n, cp_off, pd, crst;
  ssp_bank_t bank;
  logic [7:0] rd;
  int errors = 0;
  int n_tests = 0;
  ssp_setup_port #(.NUM_REGS(12)) dut_u (.i_clock(clk), .i_sys_rst(rst),
    .i_powerdown_reset_n(pdr_n), .i_setup_clock(sck), .i_setup_select_n(sel_n),
    .i_setup_data_in(sdi), .o_setup_data_out(sdo), .o_setup_data_out_oe_n(oe_n),
    .o_reg_bank(bank), .o_charge_pump_off(cp_off), .o_powerdown(pd), .o_core_reset(crst));
  ssp_host_model host_u (.o_setup_clock(sck), .o_setup_select_n(sel_n),
    .o_setup_data_in(sdi), .i_setup_data_out(sdo), .i_setup_data_out_oe_n(oe_n));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("unexpected %s: expected %h seen %h", nm, e, g);
      errors++;
    end
  endtask
  task automatic print_verdict();
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic settle();
    repeat (10) @(negedge clk);
  endtask
  // Pin rise wakes the device with a one cycle reset pulse
  task automatic t_wake();
    int k;
    k = 0;
    chk("pd", 8'h01, {7'h0, pd});
    pdr_n = 1'b1;
    while (crst !== 1'b1 && k < 10)
    begin
      @(negedge clk);
      k++;
    end
    chk("crst", 8'h01, {7'h0, crst});
    chk("pd", 8'h00, {7'h0, pd});
    chk("bank0", 8'h00, bank[0]);
    @(negedge clk);
    chk("crst", 8'h00, {7'h0, crst});
    $display("test wake done");
  endtask
  task automatic t_word();
    host_u.xfer(16'h0004, 16, 1'b0, rd);
    settle();
    chk("cp_off", 8'h01, {7'h0, cp_off});
    chk("bank0", 8'h04, bank[0]);
    $display("test word done");
  endtask
  task automatic t_split();
    host_u.xfer(16'h05a5, 16, 1'b1, rd);
    host_u.xfer(16'h0e77, 16, 1'b0, rd);
    settle();
    chk("bank5", 8'ha5, bank[5]);
    chk("bank14", 8'h00, bank[14]);
    host_u.xfer(16'h8500, 16, 1'b1, rd);
    chk("rd5s", 8'ha5, rd);
    host_u.xfer(16'h8500, 16, 1'b0, rd);
    chk("rd5", 8'ha5, rd);
    host_u.xfer(16'h8e00, 16, 1'b0, rd);
    chk("rd14", 8'h00, rd);
    chk("oe_n", 8'h01, {7'h0, oe_n});
    $display("test split done");
  endtask
  task automatic t_abort();
    host_u.xfer(16'h053c, 12, 1'b0, rd);
    host_u.xfer(16'h8500, 12, 1'b0, rd);
    chk("rd5p", 8'h0a, rd);
    settle();
    chk("oe_n", 8'h01, {7'h0, oe_n});
    chk("bank5", 8'ha5, bank[5]);
    $display("test abort done");
  endtask
  task automatic t_power();
    pdr_n = 1'b0;
    settle();
    host_u.xfer(16'h0611, 16, 1'b0, rd);
    settle();
    chk("bank6", 8'h00, bank[6]);
    chk("bank5", 8'ha5, bank[5]);
    t_wake();
    chk("cp_off", 8'h00, {7'h0, cp_off});
    chk("bank5", 8'h00, bank[5]);
    $display("test power done");
  endtask
  initial
  begin
    rst = 1'b1;
    pdr_n = 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    settle();
    t_wake();
    t_word();
    t_split();
    t_abort();
    t_power();
    print_verdict();
  end
  initial
  begin
    #200000;
    errors++;
    print_verdict();
  end
endmodule
